// File: bench/protect_link_monitor.sv
// Checker on the link between the controller and the unlock gate.
`timescale 1ns/1ps
`default_nettype none
module protect_link_monitor
	import protect_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Link signals.
	input wire logic req,
	input wire link_op_t op,
	input wire logic [LINK_ADDR_W-1:0] addr,
	input wire logic [LINK_DATA_W-1:0] wdata,
	input wire logic ack,
	input wire logic [LINK_DATA_W-1:0] rdata,
	// Gate side signals.
	input wire logic intervene_i,
	input wire logic [PROT_COUNT-1:0][7:0] prot_reg_o,
	input wire logic error_flag_o
);
	// A request is taken on an edge with req high and ack low.
	logic take;
	// A taken write aimed at one of the protected registers.
	logic pw;
	// Unlock pending; reads keep it, any other action ends it.
	logic armed_r;

	assign take = req && !ack;
	assign pw = take && op != OP_READ && addr[1:0] == 2'h0 &&
		addr[31:5] == PROT_BASE[31:5];

	// Track the unlock the way the gate must, so writes can be judged.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_r <= 1'b0;
		end else if (intervene_i) begin
			armed_r <= 1'b0;
		end else if (take && op != OP_READ) begin
			armed_r <= op == OP_STORE_B && addr == UNLOCK_ADDR;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_follows_take: assert property (take |=> ack)
		else $error("link ack missing");
	a_ack_single_pulse: assert property (ack |=> !ack)
		else $error("link ack longer than one cycle");
	a_req_held: assert property (take |=> req && $stable(addr) &&
		$stable(wdata) && $stable(op)) else $error("request not held");
	a_locked_write_fails: assert property (pw && !armed_r |=>
		error_flag_o && $stable(prot_reg_o)) else $error("locked write");
	a_unlocked_store: assert property (pw && armed_r && !intervene_i &&
		op == OP_STORE_B |=> prot_reg_o[$past(addr[4:2])] == $past(wdata))
		else $error("unlocked store lost");
	a_intervene_cancels: assert property (pw && intervene_i |=>
		error_flag_o) else $error("intervening action ignored");
	a_status_upper_zero: assert property (ack && op == OP_READ &&
		addr == STATUS_ADDR |-> rdata == {7'h00, error_flag_o})
		else $error("status read wrong");
	a_no_sw_set: assert property (take && op != OP_READ &&
		addr == STATUS_ADDR && !error_flag_o |=> !error_flag_o)
		else $error("software set the error flag");
	a_zero_clears: assert property (take && op == OP_STORE_B &&
		addr == STATUS_ADDR && !wdata[0] |=> !error_flag_o)
		else $error("error flag not cleared");
	a_quiet_keeps: assert property (!pw |=> $stable(prot_reg_o))
		else $error("protected register changed without a write");
endmodule
`default_nettype wire

// File: bench/protected_register_write_unlock_tb_top.sv
// Testbench joining controller and gate, driven over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module protected_register_write_unlock_tb_top;
	import protect_pkg::*;
	// Clock, reset and bus master signals.
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic [3:0] wb_sel = 4'hF;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic irq;
	// Non-link action into the gate, and the gate's outputs.
	logic intervene = 1'b0;
	logic [PROT_COUNT-1:0][7:0] prot;
	logic err;
	// Scratch values and tallies.
	logic [31:0] q;
	logic [31:0] dq;
	int errors = 0;
	int checks = 0;
	link_op_t bop[3] = '{OP_SET1, OP_CLR1, OP_NOT1};
	logic [7:0] bexp[3] = '{8'h40, 8'h00, 8'h40};

	protect_link_if protect_link_if_i();
	protect_cpu #(.MAX_TRIES(2)) protect_cpu_i(.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq),
		.link(protect_link_if_i));
	protect_gate #(.PROT_RESET(8'h00)) protect_gate_i(.clk_i(clk_i),
		.rst_i(rst_i), .link(protect_link_if_i), .intervene_i(intervene),
		.prot_reg_o(prot), .error_flag_o(err));
	protect_link_monitor protect_link_monitor_i(.clk_i(clk_i),
		.rst_i(rst_i), .req(protect_link_if_i.req),
		.op(protect_link_if_i.op), .addr(protect_link_if_i.addr),
		.wdata(protect_link_if_i.wdata), .ack(protect_link_if_i.ack),
		.rdata(protect_link_if_i.rdata), .intervene_i(intervene),
		.prot_reg_o(prot), .error_flag_o(err));

	// Free-running 50 MHz clock.
	initial begin
		forever #10 clk_i = ~clk_i;
	end

	// Print the tallies and the verdict, then stop.
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Compare a seen value with the expected one.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One classic cycle; held until ack is sampled, then one idle cycle.
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) begin
			errors++;
			conclude();
		end
		r = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// Order one link access (sq=0) or a full unlock sequence (sq=1).
	// The busy poll is bounded, since a hung controller must not stall.
	task automatic go(input link_op_t o, input logic [31:0] a,
		input logic [10:0] d, input logic sq, output logic [31:0] r);
		int n;
		n = 0;
		wb(1'b1, REG_ADDR, a, r);
		wb(1'b1, REG_DATA, 32'(d), r);
		wb(1'b1, REG_CTRL, (32'(o) << CTRL_OP_LSB) |
			(32'(sq) << CTRL_SEQ_BIT) | 32'h1, r);
		do begin
			wb(1'b0, REG_RESULT, 32'h0, r);
			n++;
		end while (r[RES_BUSY_BIT] !== 1'b0 && n < 40);
		if (r[RES_BUSY_BIT] !== 1'b0) begin
			errors++;
			conclude();
		end
	endtask

	// Address of protected register i.
	function automatic logic [31:0] pa(input int i);
		return PROT_BASE + 32'(i * 4);
	endfunction

	// Main sequence of scenarios.
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		go(OP_READ, STATUS_ADDR, 11'h0, 1'b0, q);
		chk(q[7:0], STATUS_RESET);
		// A store with no unlock is dropped and flagged.
		go(OP_STORE_B, pa(2), 11'h5A, 1'b0, q);
		chk(prot[2], 8'h00);
		chk(err, 1'b1);
		go(OP_READ, STATUS_ADDR, 11'h0, 1'b0, q);
		chk(q[7:0], 8'h01);
		go(OP_STORE_B, STATUS_ADDR, 11'h0, 1'b0, q);
		chk(err, 1'b0);
		go(OP_STORE_B, STATUS_ADDR, 11'hFF, 1'b0, q);
		chk(err, 1'b0);
		// Unlock with an arbitrary value, a read in between, then store.
		go(OP_STORE_B, UNLOCK_ADDR, 11'hA5, 1'b0, q);
		go(OP_READ, pa(3), 11'h0, 1'b0, q);
		chk(q[7:0], 8'h00);
		go(OP_STORE_B, pa(3), 11'h3C, 1'b0, q);
		chk(prot[3], 8'h3C);
		chk(err, 1'b0);
		go(OP_STORE_B, pa(3), 11'hC3, 1'b0, q);
		chk(prot[3], 8'h3C);
		chk(err, 1'b1);
		// Each bit operation on bit 6 after its own unlock.
		for (int i = 0; i < 3; i++) begin
			go(OP_STORE_B, UNLOCK_ADDR, 11'h0, 1'b0, q);
			go(bop[i], pa(5), 11'h600, 1'b0, q);
			chk(prot[5], bexp[i]);
		end
		// A one-cycle foreign action between unlock and store.
		go(OP_STORE_B, STATUS_ADDR, 11'h0, 1'b0, q);
		chk(err, 1'b0);
		go(OP_STORE_B, UNLOCK_ADDR, 11'h0, 1'b0, q);
		intervene <= 1'b1;
		@(posedge clk_i);
		intervene <= 1'b0;
		go(OP_STORE_B, pa(4), 11'h77, 1'b0, q);
		chk(prot[4], 8'h00);
		chk(err, 1'b1);
		// A half-word store to the unlock register does not unlock.
		go(OP_STORE_H, UNLOCK_ADDR, 11'h0, 1'b0, q);
		go(OP_STORE_B, pa(6), 11'h66, 1'b0, q);
		chk(prot[6], 8'h00);
		// Full sequences reach every protected register.
		for (int i = 0; i < PROT_COUNT; i++) begin
			go(OP_STORE_B, pa(i), 11'(8'h10 + i), 1'b1, q);
			chk(prot[i], 8'h10 + 8'(i));
			chk(q[RES_FAIL_BIT], 1'b0);
		end
		// Done interrupt: mask bits clear, then set to enable, then status cleared by writing ones.
		wb(1'b1, REG_IRQ_MASK, 32'h0, dq);
		wb(1'b0, REG_IRQ_STAT, 32'h0, q);
		chk(q[IRQ_DONE_BIT], 1'b1);
		chk(irq, 1'b0);
		wb(1'b1, REG_IRQ_MASK, 32'h3, dq);
		@(posedge clk_i);
		chk(irq, 1'b1);
		wb(1'b1, REG_IRQ_STAT, 32'h3, dq);
		@(posedge clk_i);
		chk(irq, 1'b0);
		// A foreign action held high breaks every retry.
		intervene <= 1'b1;
		go(OP_STORE_B, pa(1), 11'h99, 1'b1, q);
		intervene <= 1'b0;
		chk(q[RES_FAIL_BIT], 1'b1);
		chk(q[RES_TRIES_LSB +: TRY_W], 4'h1);
		chk(prot[1], 8'h11);
		chk(irq, 1'b1);
		wb(1'b0, REG_IRQ_STAT, 32'h0, q);
		chk(q[IRQ_FAIL_BIT], 1'b1);
		// Unmapped offset reads zero.
		wb(1'b0, 8'hF0, 32'h0, q);
		chk(q, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire

// File: design/protect_cpu.sv
// Processor-side controller running unlock sequences over the link.
`timescale 1ns/1ps
`default_nettype none
module protect_cpu
	import protect_pkg::*;
#(
	parameter int MAX_TRIES = 4
) (
	// Clock and synchronous reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Level interrupt.
	output logic irq_o,
	// Link to the gate.
	protect_link_if.cpu link
);

	// Sequence states.
	typedef enum logic [2:0] {
		H_IDLE,
		H_CLEAR,
		H_UNLOCK,
		H_WRITE,
		H_CHECK,
		H_RAW
	} host_state_t;

	host_state_t state_r;
	// Programmed job.
	logic seq_r;
	link_op_t op_r;
	logic [31:0] tgt_r;
	logic [7:0] wdata_r;
	logic [BIT_IDX_W-1:0] bit_r;
	// Outcome.
	logic [7:0] rdata_r;
	logic fail_r;
	logic [TRY_W-1:0] tries_r;
	// One-cycle completion events.
	logic done_evt_r;
	logic fail_evt_r;
	// Interrupt status and mask.
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	// Bus decode.
	logic wb_take;
	logic wr;
	logic start;
	logic [31:0] lane_m;
	logic [31:0] read_word;

	assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = wb_take && wb_we_i;
	assign lane_m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// A start while busy is ignored.
	assign start = wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0] &&
		wb_dat_i[CTRL_START_BIT] && (state_r == H_IDLE);

	// Job registers, written through byte lanes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_r <= 1'b0;
			op_r <= OP_READ;
			tgt_r <= 32'h00000000;
			wdata_r <= 8'h00;
			bit_r <= '0;
		end else if (wr) begin
			if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
				seq_r <= wb_dat_i[CTRL_SEQ_BIT];
				op_r <= link_op_t'(wb_dat_i[CTRL_OP_LSB +: 3]);
			end
			if (wb_adr_i == REG_ADDR) begin
				tgt_r <= (tgt_r & ~lane_m) | (wb_dat_i & lane_m);
			end
			if (wb_adr_i == REG_DATA && wb_sel_i[0]) begin
				wdata_r <= wb_dat_i[7:0];
			end
			if (wb_adr_i == REG_DATA && wb_sel_i[1]) begin
				bit_r <= wb_dat_i[DATA_BIT_LSB +: BIT_IDX_W];
			end
		end
	end

	// Sequence engine: one link request per state, one idle cycle between.
	// The unlock and the protected write follow with no other link access,
	// which is the hardware form of shielding the pair.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= H_IDLE;
			link.req <= 1'b0;
			link.op <= OP_READ;
			link.addr <= 32'h00000000;
			link.wdata <= 8'h00;
			link.bit_idx <= '0;
			rdata_r <= 8'h00;
			fail_r <= 1'b0;
			tries_r <= '0;
			done_evt_r <= 1'b0;
			fail_evt_r <= 1'b0;
		end else begin
			done_evt_r <= 1'b0;
			fail_evt_r <= 1'b0;
			case (state_r)
				H_IDLE: begin
					if (start) begin
						tries_r <= '0;
						// The mode bit is read from the starting write itself,
						// since seq_r only takes it at this same edge.
						state_r <= wb_dat_i[CTRL_SEQ_BIT] ? H_CLEAR : H_RAW;
					end
				end
				default: begin
					if (link.ack) begin
						link.req <= 1'b0;
						case (state_r)
							H_CLEAR: begin
								state_r <= H_UNLOCK;
							end
							H_UNLOCK: begin
								state_r <= H_WRITE; // R9
							end
							H_WRITE: begin
								state_r <= H_CHECK;
							end
							H_CHECK: begin
								// Retry while the flag stays set, up to MAX_TRIES attempts in all.
								if (link.rdata[ERR_BIT] &&
									tries_r < TRY_W'(MAX_TRIES - 1)) begin
									tries_r <= tries_r + 1'b1; // R14
									state_r <= H_CLEAR;
								end else begin
									fail_r <= link.rdata[ERR_BIT];
									fail_evt_r <= link.rdata[ERR_BIT];
									done_evt_r <= 1'b1;
									state_r <= H_IDLE;
								end
							end
							default: begin
								// Raw access ends here.
								rdata_r <= link.rdata;
								fail_r <= 1'b0;
								done_evt_r <= 1'b1;
								state_r <= H_IDLE;
							end
						endcase
					end else if (!link.req) begin
						link.req <= 1'b1;
						link.bit_idx <= bit_r;
						case (state_r)
							H_CLEAR: begin
								link.op <= OP_STORE_B;
								link.addr <= STATUS_ADDR;
								link.wdata <= 8'h00; // R14
							end
							H_UNLOCK: begin
								// Reuse the value to be stored.
								link.op <= OP_STORE_B;
								link.addr <= UNLOCK_ADDR;
								link.wdata <= wdata_r; // R15
							end
							H_CHECK: begin
								link.op <= OP_READ;
								link.addr <= STATUS_ADDR;
							end
							default: begin
								// Protected write or raw access.
								link.op <= op_r; // R2
								link.addr <= tgt_r;
								link.wdata <= wdata_r;
							end
						endcase
					end
				end
			endcase
		end
	end

	// Interrupt status: events win over a write-one clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~((wr && wb_sel_i[0] &&
				wb_adr_i == REG_IRQ_STAT) ? wb_dat_i[IRQ_W-1:0] : '0)) |
				{fail_evt_r, done_evt_r};
			if (wr && wb_sel_i[0] && wb_adr_i == REG_IRQ_MASK) begin
				irq_mask_r <= wb_dat_i[IRQ_W-1:0];
			end
		end
	end

	// Interrupt line follows the masked status one cycle later.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Read view; unmapped offsets read zero.
	always_comb begin
		read_word = 32'h00000000;
		case (wb_adr_i)
			REG_CTRL: begin
				read_word[CTRL_SEQ_BIT] = seq_r;
				read_word[CTRL_OP_LSB +: 3] = op_r;
			end
			REG_ADDR: begin
				read_word = tgt_r;
			end
			REG_DATA: begin
				read_word[7:0] = wdata_r;
				read_word[DATA_BIT_LSB +: BIT_IDX_W] = bit_r;
			end
			REG_RESULT: begin
				read_word[7:0] = rdata_r;
				read_word[RES_BUSY_BIT] = (state_r != H_IDLE);
				read_word[RES_FAIL_BIT] = fail_r;
				read_word[RES_TRIES_LSB +: TRY_W] = tries_r;
			end
			REG_IRQ_STAT: begin
				read_word[IRQ_W-1:0] = irq_stat_r;
			end
			REG_IRQ_MASK: begin
				read_word[IRQ_W-1:0] = irq_mask_r;
			end
			default: begin
				read_word = 32'h00000000;
			end
		endcase
	end

	// Every access is answered one cycle after it is taken.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_take;
			if (wb_take) begin
				wb_dat_o <= read_word;
			end
		end
	end

endmodule
`default_nettype wire

// File: design/protect_gate.sv
// Write-protection gate holding the eight protected system registers.
`timescale 1ns/1ps
`default_nettype none
module protect_gate
	import protect_pkg::*;
#(
	parameter logic [7:0] PROT_RESET = 8'h00
) (
	// Clock and synchronous reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Link from the processor side.
	protect_link_if.dev link,
	// Pulse for any non-link action, such as an interrupt acknowledge.
	input wire logic intervene_i,
	// Protected register contents as seen by the system.
	output logic [PROT_COUNT-1:0][7:0] prot_reg_o,
	// Write error flag.
	output logic error_flag_o
);

	// A request is taken in the cycle it is high and not yet answered.
	logic take;
	// The taken request changes something.
	logic is_write;
	// Address decode results.
	logic hit_unlock;
	logic hit_status;
	logic hit_prot;
	// Index of the protected register addressed.
	logic [PROT_IDX_W-1:0] prot_idx;
	// Qualified accesses.
	logic unlock_write;
	logic prot_write;
	logic status_write;
	// Failed protected write in this cycle.
	logic err_set;
	// Status register view and its value after the write.
	logic [7:0] status_now;
	logic [7:0] status_new;
	// Read data chosen for the taken request.
	logic [7:0] read_val;
	// One protected write is permitted while this is set.
	logic armed_r;

	// Applies a store or a single-bit operation to a byte.
	function automatic logic [7:0] modify(
		input link_op_t op,
		input logic [7:0] old,
		input logic [7:0] wd,
		input logic [BIT_IDX_W-1:0] b
	);
		logic [7:0] m;
		m = 8'h01 << b;
		case (op)
			OP_SET1: begin
				modify = old | m;
			end
			OP_CLR1: begin
				modify = old & ~m;
			end
			OP_NOT1: begin
				modify = old ^ m;
			end
			default: begin
				// A half-word store keeps only its low byte.
				modify = wd;
			end
		endcase
	endfunction

	// The ack term keeps one held request from being taken twice.
	assign take = link.req && !link.ack;
	assign is_write = take && (link.op != OP_READ); // R3

	// Full address compare for unlock and status; the protected decode ignores address bits 1:0.
	assign hit_unlock = (link.addr == UNLOCK_ADDR);
	assign hit_status = (link.addr == STATUS_ADDR);
	assign hit_prot = (link.addr[31:PROT_IDX_MSB+1] ==
		PROT_BASE[31:PROT_IDX_MSB+1]); // R4
	assign prot_idx = link.addr[PROT_IDX_MSB:PROT_IDX_LSB];

	// Only a byte store unlocks; the data itself is never checked.
	assign unlock_write = is_write && hit_unlock &&
		(link.op == OP_STORE_B); // R5 R10
	assign prot_write = is_write && hit_prot;
	assign status_write = is_write && hit_status;

	// A protected write without a fresh unlock is refused.
	// A foreign action in the same cycle as the write also breaks the pair.
	assign err_set = prot_write && (!armed_r || intervene_i); // R11 R16

	// Upper status bits are constant zero.
	assign status_now = {7'h00, error_flag_o}; // R12
	assign status_new = modify(link.op, status_now, link.wdata,
		link.bit_idx);

	// Arm on an unlock; anything that is not a read disarms.
	// An intervening event wins over a simultaneous unlock, since the
	// sequence it breaks cannot be trusted either way.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_r <= 1'b0;
		end else if (intervene_i) begin
			// Something other than a read came between.
			armed_r <= 1'b0; // R8
		end else if (unlock_write) begin
			armed_r <= 1'b1; // R5
		end else if (is_write) begin
			// The one permitted write, or any other write, relocks.
			armed_r <= 1'b0; // R6 R8
		end
		// Reads fall through and leave the unlock standing.
		// R7
	end

	// One register per protected entry.
	for (genvar g = 0; g < PROT_COUNT; g++) begin : g_prot
		// Writes land only while armed; a refused write keeps contents.
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				prot_reg_o[g] <= PROT_RESET;
			end else if (prot_write && armed_r && !intervene_i &&
				(prot_idx == PROT_IDX_W'(g))) begin // R8
				prot_reg_o[g] <= modify(link.op, prot_reg_o[g],
					link.wdata, link.bit_idx); // R1 R6
			end
		end
	end

	// Error flag: hardware set wins over a software clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			error_flag_o <= STATUS_RESET[ERR_BIT]; // R12
		end else if (err_set) begin
			error_flag_o <= 1'b1; // R11
		end else if (status_write && !status_new[ERR_BIT]) begin
			// Writing zero clears; a one written by software is dropped.
			error_flag_o <= 1'b0; // R13
		end
	end

	// Read mux; the unlock register is write-only and reads zero.
	always_comb begin
		read_val = 8'h00;
		if (hit_status) begin
			read_val = status_now;
		end else if (hit_prot) begin
			// Protected registers read freely at any time.
			read_val = prot_reg_o[prot_idx]; // R3
		end
	end

	// Answer every taken request one cycle later.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.ack <= 1'b0;
		end else begin
			link.ack <= take;
		end
	end

	// Read data is captured with the answer and holds until the next read.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.rdata <= 8'h00;
		end else if (take && (link.op == OP_READ)) begin
			link.rdata <= read_val;
		end
	end

endmodule
`default_nettype wire

// File: design/protect_link_if.sv
// Link between the processor-side controller and the unlock gate.
`timescale 1ns/1ps
`default_nettype none
interface protect_link_if;
	import protect_pkg::*;

	// Request held by the processor side until ack.
	logic req;
	link_op_t op;
	logic [LINK_ADDR_W-1:0] addr;
	logic [LINK_DATA_W-1:0] wdata;
	logic [BIT_IDX_W-1:0] bit_idx;
	// One-cycle answer and read data from the gate.
	logic ack;
	logic [LINK_DATA_W-1:0] rdata;

	// Gate end.
	modport dev(input req, op, addr, wdata, bit_idx, output ack, rdata);
	// Processor end.
	modport cpu(output req, op, addr, wdata, bit_idx, input ack, rdata);
endinterface
`default_nettype wire

// File: design/protect_pkg.sv
// Constants and types shared by the unlock gate and its bus controller.
// Contract
// (R1) Protected write only right after unlock write.
// (R2) Software uses stores or single-bit set/clear/invert.
// (R3) Reads need no unlock, leave protection untouched.
// (R4) Eight protected registers share one unlock register.
// (R5) Any unlock data value counts as unlock.
// (R6) One protected write per unlock, then relock.
// (R7) Reads between unlock and write keep unlock.
// (R8) Any other intervening action cancels the unlock.
// (R9) Software shields the pair from interrupts.
// (R10) Unlock register: 8-bit, write-only, byte writes.
// (R11) Invalid protected write sets error flag bit.
// (R12) Status: 8-bit, upper bits zero, resets 00.
// (R13) Error flag cleared by zero, never set by software.
// (R14) Clear flag, unlock, write, check, retry.
// (R15) Unlock value: zero or value to store.
// (R16) Unlocked-less protected write discarded, counted invalid.
package protect_pkg;

	// Link address and data widths.
	localparam int LINK_ADDR_W = 32;
	localparam int LINK_DATA_W = 8;
	localparam int BIT_IDX_W = 3;

	// Unlock command register, write-only.
	localparam logic [31:0] UNLOCK_ADDR = 32'hFFFFF1FC;
	// Protection status register.
	localparam logic [31:0] STATUS_ADDR = 32'hFFFFF802;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int ERR_BIT = 0;

	// Protected registers sit one per word above this base.
	localparam logic [31:0] PROT_BASE = 32'hFFFFF900;
	localparam int PROT_IDX_W = 3;
	localparam int PROT_COUNT = 8;
	localparam int PROT_IDX_LSB = 2;
	localparam int PROT_IDX_MSB = PROT_IDX_LSB + PROT_IDX_W - 1;

	// Access kinds on the link.
	typedef enum logic [2:0] {
		OP_READ,
		OP_STORE_B,
		OP_STORE_H,
		OP_SET1,
		OP_CLR1,
		OP_NOT1
	} link_op_t;

	// Controller register offsets on its Wishbone port.
	localparam int WB_ADR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_RESULT = 8'h0C;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;

	// Control register fields.
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_SEQ_BIT = 1;
	localparam int CTRL_OP_LSB = 4;
	// Data register fields.
	localparam int DATA_BIT_LSB = 8;
	// Result register fields.
	localparam int RES_BUSY_BIT = 8;
	localparam int RES_FAIL_BIT = 9;
	localparam int RES_TRIES_LSB = 12;
	localparam int TRY_W = 4;
	// Interrupt bits: done and failed.
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;

endpackage
